// ===== rtl/iwr_pkg.sv
// Interpreter register bank constants.
// Used with package-qualified names only.
package iwr_pkg;
  localparam int unsigned WORD_W      = 36;
  localparam int unsigned NUM_SLOTS   = 6;
  localparam int unsigned FLAG_W      = 16;
  localparam int unsigned LATCH_W     = 14;
  localparam int unsigned ADDR_W      = 4;
  // Word indices; byte address is four times
  localparam logic [3:0] IDX_SECOND   = 4'h0;
  localparam logic [3:0] IDX_SLOT0    = 4'h1;
  localparam logic [3:0] IDX_SLOT5    = 4'h6;
  localparam logic [3:0] IDX_FLAGS1   = 4'h7;
  localparam logic [3:0] IDX_FLAGS2   = 4'h8;
  localparam logic [3:0] IDX_LATCH    = 4'h9;
  localparam logic [3:0] IDX_COND     = 4'hA;
  localparam logic [3:0] IDX_PORT     = 4'hB;
  localparam logic [3:0] IDX_CTRL     = 4'hC;
  // Latch positions
  localparam int unsigned LAT_EE_CLK  = 0;
  localparam int unsigned LAT_EE_PWR  = 7;
  localparam int unsigned LAT_DIR     = 8;
  localparam int unsigned LAT_BATT    = 9;
  localparam int unsigned LAT_SEL_LO  = 10;
  localparam int unsigned LAT_SEL_HI  = 11;
  localparam int unsigned LAT_TICK    = 12;
  localparam int unsigned LAT_ISRC    = 13;
  // Software may touch latches 1..6 and 8..13 only
  localparam logic [13:0] LATCH_SW_MASK = 14'h3F7E;
  // Bank one flag positions
  localparam int unsigned FLG_LONG_TMR  = 10;
  localparam int unsigned FLG_SHORT_TMR = 11;
  localparam int unsigned FLG_PORT_LO   = 12;
  // Condition bit positions
  localparam int unsigned CND_ZERO    = 0;
  localparam int unsigned CND_MINUS   = 1;
  localparam int unsigned CND_PLUS    = 2;
  // Status-update kinds from the interpreter
  typedef enum logic [2:0] {
    UPD_NONE  = 3'b000,
    UPD_ARITH = 3'b001,
    UPD_OTHER = 3'b010,
    UPD_ADC   = 3'b011,
    UPD_CMP   = 3'b100
  } iwr_upd_t;
  typedef enum logic [1:0] {
    SLOT0_KEEP  = 2'b00,
    SLOT0_CLEAR = 2'b01,
    SLOT0_REM   = 2'b10
  } iwr_slot0_t;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [35:0] RST_WIDE = 36'h0_0000_0000;
  localparam logic [31:0] BAD_READ = 32'hDEAD_BEEF;
endpackage

// ===== rtl/iwr_regs.sv
// Interpreter work registers, slots, flags, latches, port and status.
// Assumes the ALU on this clock, Avalon-MM access, async pins.
//
// Overview of operation
// [R1] Second work register: eight BCD digits, sign
// [R2] Second register feeds operand, takes constants, counters
// [R3] Six storage slots, same nine-nibble format
// [R4] Slot zero cleared by multiply, holds remainder
// [R5] Two sixteen-flag banks, select persists until changed
// [R6] Bank one: H segments, timers, port buffer
// [R7] Latches one to six drive output pins
// [R8] EEPROM clock and supply pins interpreter-only
// [R9] Fourteen latches; zero and seven software-locked
// [R10] Latch eight sets port direction
// [R11] Latches nine to eleven pick ADC input
// [R12] Latch twelve picks one or sixteen hertz
// [R13] Latch thirteen enables current source with supply
// [R14] Port output through four-bit latch, open source
// [R15] Port input via Schmitt buffers to ALU; when latch eight sets output the ALU reads the port latch instead
// [R16] Port activity wakes device from low power
// [R17] Three status bits, kept unless updated
// [R18] Conditional jump tests one status bit
// [R19] Arithmetic sets plus bit from result sign
// [R20] Plus set on success or ADC in range
// [R21] Minus set on negative, error, out-of-range
// [R22] Zero set on zero, equal, under range
// [R23] Reset clears latches, flags, status; bank one
`timescale 1ns/1ps
`default_nettype none
module iwr_regs (
  // Clock and reset
  input  wire  logic        ref_clk_i,
  input  wire  logic        rst_n_i,
  input  wire  logic        clk_en_i,
  // Avalon-MM slave
  input  wire  logic [5:0]  avs_address_i,
  input  wire  logic        avs_read_i,
  input  wire  logic        avs_write_i,
  input  wire  logic [31:0] avs_writedata_i,
  input  wire  logic [3:0]  avs_byteenable_i,
  output logic [31:0]       avs_readdata_o,
  output logic              avs_waitrequest_o,
  output logic [1:0]        avs_response_o,
  // Interpreter ALU side
  input  wire  logic        alu_b_we_i,
  input  wire  logic [35:0] alu_b_data_i,
  output logic [35:0]       alu_b_o,
  input  wire  logic        alu_slot_we_i,
  input  wire  logic [2:0]  alu_slot_sel_i,
  input  wire  logic [35:0] alu_slot_data_i,
  input  wire  logic [1:0]  alu_slot0_op_i,
  input  wire  logic [35:0] alu_remainder_i,
  input  wire  logic        alu_pick_bank_one_i,
  input  wire  logic        alu_pick_bank_two_i,
  input  wire  logic        alu_flag_set_i,
  input  wire  logic        alu_flag_clr_i,
  input  wire  logic [3:0]  alu_flag_idx_i,
  output logic              alu_flag_test_o,
  input  wire  logic        alu_latch_set_i,
  input  wire  logic        alu_latch_clr_i,
  input  wire  logic [3:0]  alu_latch_idx_i,
  input  wire  logic        alu_sys_latch_we_i,
  input  wire  logic        alu_ee_clk_i,
  input  wire  logic        alu_ee_pwr_i,
  input  wire  logic        alu_port_we_i,
  input  wire  logic [3:0]  alu_port_data_i,
  output logic [3:0]        alu_port_in_o,
  input  wire  logic [2:0]  alu_upd_i,
  input  wire  logic        alu_res_neg_i,
  input  wire  logic        alu_res_zero_i,
  input  wire  logic        alu_error_i,
  input  wire  logic        alu_adc_over_i,
  input  wire  logic        alu_adc_under_i,
  input  wire  logic [1:0]  alu_jump_sel_i,
  output logic              alu_jump_take_o,
  input  wire  logic [6:0]  seg_h_i,
  input  wire  logic        tick_long_i,
  input  wire  logic        tick_short_i,
  output logic              tick_sel_o,
  input  wire  logic        tick_1hz_i,
  input  wire  logic        tick_16hz_i,
  // Pins and analog control
  output logic [5:0]        general_out_pin_o,
  output logic              eeprom_clock_pin_o,
  output logic              eeprom_supply_pin_o,
  input  wire  logic [3:0]  port_line_i,
  output logic [3:0]        port_line_o,
  output logic [3:0]        port_line_oe_n_o,
  input  wire  logic        low_power_i,
  output logic              wake_o,
  input  wire  logic        switched_sensor_supply_i,
  output logic              current_source_on_o,
  output logic              battery_select_o,
  output logic [3:0]        analog_in_sel_o
);
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  logic [35:0] second_work_reg_r;
  logic [35:0] store_slot_r [iwr_pkg::NUM_SLOTS];
  logic [15:0] flag_bank_one_r;
  logic [15:0] flag_bank_two_r;
  logic        bank_two_sel_r;
  logic [13:0] latch_array_r;
  logic [3:0]  port_latch_r;
  logic [2:0]  condition_bits_r;
  logic [2:0]  condition_bits_nxt;
  logic [3:0]  port_meta_r;
  logic [3:0]  port_sync_r;
  logic [3:0]  port_prev_r;
  logic        ack_r;

  // Bus decode
  wire         bus_req    = (avs_read_i | avs_write_i) & clk_en_i;
  wire         bus_go     = bus_req & ~ack_r;
  wire [3:0]   reg_idx    = avs_address_i[5:2];
  wire         hit_second = (reg_idx == iwr_pkg::IDX_SECOND);
  wire         hit_slot   = (reg_idx >= iwr_pkg::IDX_SLOT0) && (reg_idx <= iwr_pkg::IDX_SLOT5);
  wire [2:0]   slot_idx   = 3'(reg_idx - iwr_pkg::IDX_SLOT0);
  wire         hit_f1     = (reg_idx == iwr_pkg::IDX_FLAGS1);
  wire         hit_f2     = (reg_idx == iwr_pkg::IDX_FLAGS2);
  wire         hit_lat    = (reg_idx == iwr_pkg::IDX_LATCH);
  wire         hit_cond   = (reg_idx == iwr_pkg::IDX_COND);
  wire         hit_port   = (reg_idx == iwr_pkg::IDX_PORT);
  wire         hit_ctrl   = (reg_idx == iwr_pkg::IDX_CTRL);
  // Address bit 1 selects the sign nibble of wide registers
  wire         hi_half    = avs_address_i[1];
  wire         mapped     = (hit_second | hit_slot | hit_f1 | hit_f2 | hit_lat | hit_cond | hit_port | hit_ctrl)
                            & (avs_address_i[0] == 1'b0);
  wire         sw_wr      = bus_go & avs_write_i & mapped;
  wire [31:0]  be_mask    = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  function automatic logic [35:0] wide_merge(input logic [35:0] old, input logic hi,
                                             input logic [31:0] wd, input logic [31:0] m);
    logic [31:0] lo_new;
    logic [3:0]  hi_new;
    lo_new = (old[31:0] & ~m) | (wd & m);
    hi_new = m[0] ? wd[3:0] : old[35:32];
    wide_merge = hi ? {hi_new, old[31:0]} : {old[35:32], lo_new};
  endfunction

  wire [35:0] slot_rd    = store_slot_r[slot_idx];
  wire [35:0] wide_rd    = hit_second ? second_work_reg_r : slot_rd;
  wire [31:0] wide_word  = hi_half ? {28'h0000000, wide_rd[35:32]} : wide_rd[31:0];
  wire [31:0] rd_mux     = (hit_second | hit_slot) ? wide_word :
                           hit_f1   ? {16'h0000, flag_bank_one_r} :
                           hit_f2   ? {16'h0000, flag_bank_two_r} :
                           hit_lat  ? {18'h00000, latch_array_r} :
                           hit_cond ? {29'h00000000, condition_bits_r} :
                           hit_port ? {24'h000000, port_sync_r, port_latch_r} :
                           hit_ctrl ? {31'h00000000, bank_two_sel_r} : iwr_pkg::RST_WORD;

  // One wait cycle per access, answered on the second edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_r             <= 1'b0;
      avs_readdata_o    <= iwr_pkg::RST_WORD;
      avs_response_o    <= RESP_OK;
    end else if (clk_en_i) begin
      ack_r             <= bus_go;
      if (bus_go) begin
        avs_readdata_o  <= mapped ? rd_mux : iwr_pkg::BAD_READ;
        avs_response_o  <= mapped ? RESP_OK : RESP_ERR;
      end
    end
  end
  assign avs_waitrequest_o = ~ack_r;

  // ALU write wins over software
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      second_work_reg_r <= iwr_pkg::RST_WIDE;
    end else if (clk_en_i) begin
      if (alu_b_we_i) begin
        second_work_reg_r <= alu_b_data_i; // [R2]
      end else if (sw_wr && hit_second) begin
        second_work_reg_r <= wide_merge(second_work_reg_r, hi_half, avs_writedata_i, be_mask); // [R1]
      end
    end
  end
  assign alu_b_o = second_work_reg_r; // [R2]

  genvar gs;
  generate
    for (gs = 0; gs < iwr_pkg::NUM_SLOTS; gs++) begin : g_slot
      wire alu_hit = alu_slot_we_i && (alu_slot_sel_i == 3'(gs));
      wire sw_hit  = sw_wr && hit_slot && (slot_idx == 3'(gs));
      wire s0_clr  = (gs == 0) && (alu_slot0_op_i == iwr_pkg::SLOT0_CLEAR);
      wire s0_rem  = (gs == 0) && (alu_slot0_op_i == iwr_pkg::SLOT0_REM);
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          store_slot_r[gs] <= iwr_pkg::RST_WIDE;
        end else if (clk_en_i) begin
          if (s0_clr) begin
            store_slot_r[gs] <= iwr_pkg::RST_WIDE; // [R4]
          end else if (s0_rem) begin
            store_slot_r[gs] <= alu_remainder_i; // [R4]
          end else if (alu_hit) begin
            store_slot_r[gs] <= alu_slot_data_i; // [R3]
          end else if (sw_hit) begin
            store_slot_r[gs] <= wide_merge(store_slot_r[gs], hi_half, avs_writedata_i, be_mask); // [R3]
          end
        end
      end
    end
  endgenerate

  // Flag banks; hardware-fed bank-one bits overwrite each cycle
  wire [15:0] flag_onehot = 16'h0001 << alu_flag_idx_i;
  wire [15:0] sw_f_mask   = be_mask[15:0];
  wire [15:0] hw_one_mask = 16'hFCFE; // [R6]
  wire [15:0] hw_one_val  = {port_sync_r, tick_short_i, tick_long_i, 2'b00, seg_h_i, 1'b0};
  wire [15:0] f1_alu      = alu_flag_set_i ? (flag_bank_one_r | flag_onehot) :
                            alu_flag_clr_i ? (flag_bank_one_r & ~flag_onehot) : flag_bank_one_r;
  wire [15:0] f2_alu      = alu_flag_set_i ? (flag_bank_two_r | flag_onehot) :
                            alu_flag_clr_i ? (flag_bank_two_r & ~flag_onehot) : flag_bank_two_r;
  wire [15:0] f1_sw       = (sw_wr && hit_f1) ? ((flag_bank_one_r & ~sw_f_mask) | (avs_writedata_i[15:0] & sw_f_mask))
                                              : flag_bank_one_r;
  wire [15:0] f1_pre      = bank_two_sel_r ? f1_sw : ((alu_flag_set_i | alu_flag_clr_i) ? f1_alu : f1_sw);
  wire [15:0] f2_sw       = (sw_wr && hit_f2) ? ((flag_bank_two_r & ~sw_f_mask) | (avs_writedata_i[15:0] & sw_f_mask))
                                              : flag_bank_two_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flag_bank_one_r <= 16'h0000; // [R23]
      flag_bank_two_r <= 16'h0000; // [R23]
      bank_two_sel_r  <= 1'b0; // [R23]
    end else if (clk_en_i) begin
      flag_bank_one_r <= (f1_pre & ~hw_one_mask) | (hw_one_val & hw_one_mask); // [R6]
      flag_bank_two_r <= (bank_two_sel_r && (alu_flag_set_i | alu_flag_clr_i)) ? f2_alu : f2_sw; // [R5]
      if (alu_pick_bank_two_i) begin
        bank_two_sel_r <= 1'b1; // [R5]
      end else if (alu_pick_bank_one_i) begin
        bank_two_sel_r <= 1'b0; // [R5]
      end else if (sw_wr && hit_ctrl && avs_byteenable_i[0]) begin
        bank_two_sel_r <= avs_writedata_i[0];
      end
    end
  end
  wire [15:0] active_bank = bank_two_sel_r ? flag_bank_two_r : flag_bank_one_r;

  // Digit latches
  wire [13:0] lat_onehot = 14'h0001 << alu_latch_idx_i;
  wire [13:0] lat_sw_msk = be_mask[13:0] & iwr_pkg::LATCH_SW_MASK; // [R9]
  wire [13:0] lat_after_sw = (sw_wr && hit_lat) ? ((latch_array_r & ~lat_sw_msk) | (avs_writedata_i[13:0] & lat_sw_msk))
                                                : latch_array_r;
  wire [13:0] lat_alu_msk = lat_onehot & iwr_pkg::LATCH_SW_MASK; // [R9]
  wire [13:0] lat_after_alu = alu_latch_set_i ? (lat_after_sw | lat_alu_msk) :
                              alu_latch_clr_i ? (lat_after_sw & ~lat_alu_msk) : lat_after_sw;
  wire [13:0] sys_msk = 14'h0081;
  wire [13:0] sys_val = {6'h00, alu_ee_pwr_i, 6'h00, alu_ee_clk_i};
  wire [13:0] lat_final = alu_sys_latch_we_i ? ((lat_after_alu & ~sys_msk) | sys_val) : lat_after_alu; // [R8]

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      latch_array_r <= 14'h0000; // [R23]
      port_latch_r  <= 4'h0;
    end else if (clk_en_i) begin
      latch_array_r <= lat_final; // [R9]
      if (alu_port_we_i) begin
        port_latch_r <= alu_port_data_i; // [R14]
      end else if (sw_wr && hit_port && avs_byteenable_i[0]) begin
        port_latch_r <= avs_writedata_i[3:0]; // [R14]
      end
    end
  end

  // Port input synchroniser stands in for the Schmitt buffers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      port_meta_r <= 4'h0;
      port_sync_r <= 4'h0;
      port_prev_r <= 4'h0;
    end else if (clk_en_i) begin
      port_meta_r <= port_line_i;
      port_sync_r <= port_meta_r; // [R15]
      port_prev_r <= port_sync_r;
    end
  end

  // Status logic
  always_comb begin
    condition_bits_nxt = condition_bits_r; // [R17]
    case (iwr_pkg::iwr_upd_t'(alu_upd_i))
      iwr_pkg::UPD_ARITH: begin
        condition_bits_nxt = {~alu_res_neg_i, alu_res_neg_i, alu_res_zero_i}; // [R19] [R21] [R22]
      end
      iwr_pkg::UPD_OTHER: begin
        condition_bits_nxt = {~alu_error_i, alu_error_i, alu_res_zero_i}; // [R20] [R21] [R22]
      end
      iwr_pkg::UPD_ADC: begin
        condition_bits_nxt = {~(alu_adc_over_i | alu_adc_under_i),
                              alu_adc_over_i | alu_adc_under_i, alu_adc_under_i}; // [R20] [R21] [R22]
      end
      iwr_pkg::UPD_CMP: begin
        condition_bits_nxt = {~alu_res_neg_i & ~alu_res_zero_i, alu_res_neg_i, alu_res_zero_i}; // [R22]
      end
      default: begin
        condition_bits_nxt = condition_bits_r; // [R17]
      end
    endcase
  end

  // Jump select: 0 zero, 1 minus, 2 plus, 3 active-bank flag
  wire jump_take_nxt = (alu_jump_sel_i == 2'd3) ? active_bank[alu_flag_idx_i]
                                                : condition_bits_nxt[alu_jump_sel_i]; // [R18]
  wire [3:0] sel_dec = latch_array_r[iwr_pkg::LAT_BATT] ? 4'h0 :
                       (4'h1 << {latch_array_r[iwr_pkg::LAT_SEL_HI], latch_array_r[iwr_pkg::LAT_SEL_LO]}); // [R11]
  wire port_out = latch_array_r[iwr_pkg::LAT_DIR]; // [R10]

  // Registered outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      condition_bits_r    <= 3'b000; // [R23]
      alu_jump_take_o     <= 1'b0;
      alu_flag_test_o     <= 1'b0;
      alu_port_in_o       <= 4'h0;
      tick_sel_o          <= 1'b0;
      general_out_pin_o   <= 6'h00;
      eeprom_clock_pin_o  <= 1'b0;
      eeprom_supply_pin_o <= 1'b0;
      port_line_o         <= 4'h0;
      port_line_oe_n_o    <= 4'hF;
      wake_o              <= 1'b0;
      current_source_on_o <= 1'b0;
      battery_select_o    <= 1'b0;
      analog_in_sel_o     <= 4'h0;
    end else if (clk_en_i) begin
      condition_bits_r    <= condition_bits_nxt; // [R17]
      alu_jump_take_o     <= jump_take_nxt; // [R18]
      alu_flag_test_o     <= active_bank[alu_flag_idx_i]; // [R5]
      alu_port_in_o       <= port_out ? port_latch_r : port_sync_r; // [R15]
      tick_sel_o          <= latch_array_r[iwr_pkg::LAT_TICK] ? tick_16hz_i : tick_1hz_i; // [R12]
      general_out_pin_o   <= latch_array_r[6:1]; // [R7]
      eeprom_clock_pin_o  <= latch_array_r[iwr_pkg::LAT_EE_CLK]; // [R8]
      eeprom_supply_pin_o <= latch_array_r[iwr_pkg::LAT_EE_PWR]; // [R8]
      port_line_o         <= port_latch_r; // [R14]
      // Open source: drive only the high level, float for low or input
      port_line_oe_n_o    <= ~({4{port_out}} & port_latch_r); // [R10] [R14]
      wake_o              <= low_power_i && (port_sync_r != port_prev_r); // [R16]
      current_source_on_o <= latch_array_r[iwr_pkg::LAT_ISRC] & switched_sensor_supply_i; // [R13]
      battery_select_o    <= latch_array_r[iwr_pkg::LAT_BATT]; // [R11]
      analog_in_sel_o     <= sel_dec; // [R11]
    end
  end
endmodule // iwr_regs
`default_nettype wire

// ===== testbench/iwr_pin_model.sv
// Pin model: open-source port lines, pull-down, outside driver.
// The bench steers the outside driver.
`timescale 1ns/1ps
`default_nettype none
module iwr_pin_model (
  // From the device
  input wire logic [3:0] dev_out_i,
  input wire logic [3:0] dev_oe_n_i,
  // Outside driver
  input wire logic       ext_en_i,
  input wire logic [3:0] ext_val_i,
  // Resolved line level
  output logic [3:0]     line_o
);
  // Open-source drivers only pull high: wired OR
  assign line_o = (dev_out_i & ~dev_oe_n_i) | (ext_en_i ? ext_val_i : 4'h0);
endmodule // iwr_pin_model
`default_nettype wire

// ===== testbench/iwr_regs_asserts.sv
// Checker for iwr_regs pins, port drive and status.
// Sees only top ports; bound to iwr_regs.
`timescale 1ns/1ps
`default_nettype none
module iwr_regs_asserts (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       clk_en_i,
  // Interpreter side
  input wire logic       alu_sys_latch_we_i,
  input wire logic       alu_ee_clk_i,
  input wire logic       alu_ee_pwr_i,
  input wire logic [2:0] alu_upd_i,
  input wire logic       alu_res_neg_i,
  input wire logic [1:0] alu_jump_sel_i,
  input wire logic       alu_jump_take_o,
  // Pins and analog control
  input wire logic       eeprom_clock_pin_o,
  input wire logic       eeprom_supply_pin_o,
  input wire logic       switched_sensor_supply_i,
  input wire logic       current_source_on_o,
  input wire logic       battery_select_o,
  input wire logic [3:0] analog_in_sel_o,
  input wire logic       low_power_i,
  input wire logic       wake_o,
  input wire logic [3:0] port_line_o,
  input wire logic [3:0] port_line_oe_n_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_idle;
    clk_en_i && alu_upd_i == 3'h0 && alu_jump_sel_i == 2'h0;
  endsequence
  sequence s_arith_neg;
    clk_en_i && alu_upd_i == 3'h1 && alu_res_neg_i && alu_jump_sel_i == 2'h1;
  endsequence
  sequence s_arith_pos;
    clk_en_i && alu_upd_i == 3'h1 && !alu_res_neg_i && alu_jump_sel_i == 2'h2;
  endsequence
  ee_pins_a: assert property (
    alu_sys_latch_we_i && clk_en_i |-> ##2 eeprom_clock_pin_o == $past(alu_ee_clk_i, 2)
      && eeprom_supply_pin_o == $past(alu_ee_pwr_i, 2))
    else $error("eeprom pins wrong");
  ee_locked_a: assert property (
    $changed({eeprom_clock_pin_o, eeprom_supply_pin_o}) |-> $past(alu_sys_latch_we_i, 2))
    else $error("eeprom pin moved alone");
  isrc_off_a: assert property (
    !switched_sensor_supply_i && !$past(switched_sensor_supply_i) |-> !current_source_on_o)
    else $error("source on without supply");
  batt_mux_a: assert property (
    battery_select_o |-> analog_in_sel_o == 4'h0)
    else $error("input selected in battery check");
  wake_cause_a: assert property (
    wake_o |-> $past(low_power_i))
    else $error("wake outside low power");
  open_src_a: assert property (
    (~port_line_oe_n_o & ~port_line_o) == 4'h0)
    else $error("port drives a low level");
  plus_arith_a: assert property (s_arith_pos |=> alu_jump_take_o)
    else $error("plus jump missed");
  minus_arith_a: assert property (s_arith_neg |=> alu_jump_take_o)
    else $error("minus jump missed");
  status_keep_a: assert property (s_idle ##1 s_idle |=> $stable(alu_jump_take_o))
    else $error("status moved without update");
endmodule // iwr_regs_asserts
bind iwr_regs iwr_regs_asserts u_chk (.*);
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for iwr_regs.
// Assumes the pin model on the port lines.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk_i = 1'b0;
  logic rst_n_i, clk_en_i, avs_read_i, avs_write_i, alu_b_we_i, alu_slot_we_i;
  logic alu_pick_bank_one_i, alu_pick_bank_two_i, alu_flag_set_i, alu_flag_clr_i;
  logic alu_latch_set_i, alu_latch_clr_i, alu_sys_latch_we_i, alu_ee_clk_i, alu_ee_pwr_i;
  logic alu_port_we_i, alu_res_neg_i, alu_res_zero_i, alu_error_i, alu_adc_over_i;
  logic alu_adc_under_i, tick_long_i, tick_short_i, tick_1hz_i, tick_16hz_i;
  logic low_power_i, switched_sensor_supply_i, ext_en;
  logic [5:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdat;
  logic [3:0]  avs_byteenable_i, alu_flag_idx_i, alu_latch_idx_i, alu_port_data_i, ext_val;
  logic [35:0] alu_b_data_i, alu_slot_data_i, alu_remainder_i, alu_b_o;
  logic [2:0]  alu_slot_sel_i, alu_upd_i;
  logic [1:0]  alu_slot0_op_i, alu_jump_sel_i, avs_response_o, rsp;
  logic [6:0]  seg_h_i;
  logic [5:0]  general_out_pin_o;
  logic [3:0]  alu_port_in_o, port_line_o, port_line_oe_n_o, analog_in_sel_o;
  logic avs_waitrequest_o, alu_flag_test_o, alu_jump_take_o, tick_sel_o, wake_o;
  logic eeprom_clock_pin_o, eeprom_supply_pin_o, current_source_on_o, battery_select_o;
  wire logic [3:0] port_line_i;
  int num_errors, total_checks, cycles, wake_cnt;
  // {upd, neg, zero, err, over, under, plus/minus/zero}
  logic [10:0] tbl [10] = '{11'b001_10000_010, 11'b001_00000_100, 11'b010_00000_100,
    11'b010_00100_010, 11'b011_00000_100, 11'b011_00010_010, 11'b011_00001_011,
    11'b100_01000_001, 11'b100_10000_010, 11'b100_00000_100};

  iwr_regs uut (.*);
  iwr_pin_model pins (.dev_out_i(port_line_o), .dev_oe_n_i(port_line_oe_n_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .line_o(port_line_i));

  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (wake_o === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cycles == 6000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rdat = avs_readdata_o;
    rsp = avs_response_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50) num_errors++;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(36'(rdat), 36'(e));
  endtask

  initial begin
    {rst_n_i, avs_read_i, avs_write_i, alu_b_we_i, alu_slot_we_i, alu_pick_bank_one_i,
      alu_pick_bank_two_i, alu_flag_set_i, alu_flag_clr_i, alu_latch_set_i, alu_latch_clr_i,
      alu_sys_latch_we_i, alu_ee_clk_i, alu_ee_pwr_i, alu_port_we_i, alu_res_neg_i,
      alu_res_zero_i, alu_error_i, alu_adc_over_i, alu_adc_under_i, tick_long_i, tick_short_i,
      tick_1hz_i, tick_16hz_i, low_power_i, switched_sensor_supply_i, ext_en, avs_address_i,
      avs_writedata_i, alu_flag_idx_i, alu_latch_idx_i, alu_port_data_i, ext_val, alu_b_data_i,
      alu_slot_data_i, alu_remainder_i, alu_slot_sel_i, alu_upd_i, alu_slot0_op_i,
      alu_jump_sel_i, seg_h_i, cycles, wake_cnt, num_errors, total_checks} = '0;
    clk_en_i = 1'b1;
    avs_byteenable_i = 4'hF;
    cyc(12);
    rst_n_i <= 1'b1;
    rchk(6'h24, 32'h0);
    rchk(6'h28, 32'h0);
    rchk(6'h30, 32'h0);
    for (int k = 0; k < 7; k++) begin
      bus(1'b1, 6'(k * 4), 32'h1234_5670 + 32'(k));
      bus(1'b1, 6'(k * 4 + 2), 32'(k + 8));
    end
    for (int k = 0; k < 7; k++) begin
      rchk(6'(k * 4), 32'h1234_5670 + 32'(k));
      rchk(6'(k * 4 + 2), 32'(k + 8));
    end
    chk(alu_b_o, 36'h8_1234_5670);
    @(posedge ref_clk_i);
    alu_b_we_i <= 1'b1;
    alu_b_data_i <= 36'h1_9876_5432;
    alu_slot_we_i <= 1'b1;
    alu_slot_sel_i <= 3'h5;
    alu_slot_data_i <= 36'h0_5555_AAAA;
    @(posedge ref_clk_i);
    {alu_b_we_i, alu_slot_we_i} <= 2'b00;
    alu_slot0_op_i <= 2'h2;
    alu_remainder_i <= 36'h0_0000_0042;
    @(posedge ref_clk_i);
    alu_slot0_op_i <= 2'h0;
    chk(alu_b_o, 36'h1_9876_5432);
    rchk(6'h18, 32'h5555_AAAA);
    rchk(6'h04, 32'h42);
    @(posedge ref_clk_i);
    alu_slot0_op_i <= 2'h1;
    @(posedge ref_clk_i);
    alu_slot0_op_i <= 2'h0;
    rchk(6'h04, 32'h0);
    bus(1'b1, 6'h24, 32'h3FFF);
    tick_16hz_i <= 1'b1;
    switched_sensor_supply_i <= 1'b1;
    rchk(6'h24, 32'h3F7E);
    chk(36'(general_out_pin_o), 36'h3F);
    chk(36'({battery_select_o, analog_in_sel_o}), 36'h10);
    chk(36'(current_source_on_o), 36'h1);
    chk(36'(tick_sel_o), 36'h1);
    switched_sensor_supply_i <= 1'b0;
    cyc(2);
    chk(36'(current_source_on_o), 36'h0);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 6'h24, 32'(k) << 10);
      cyc(2);
      chk(36'(analog_in_sel_o), 36'(4'h1 << k));
    end
    chk(36'(tick_sel_o), 36'h0);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk_i);
      alu_latch_set_i <= (k < 2);
      alu_latch_idx_i <= k[0] ? 4'h3 : 4'h0;
    end
    cyc(2);
    chk(36'({eeprom_clock_pin_o, general_out_pin_o}), 36'h04);
    alu_sys_latch_we_i <= 1'b1;
    {alu_ee_clk_i, alu_ee_pwr_i} <= 2'b11;
    @(posedge ref_clk_i);
    alu_sys_latch_we_i <= 1'b0;
    rchk(6'h24, 32'hC89);
    bus(1'b1, 6'h24, 32'h100);
    bus(1'b1, 6'h2C, 32'h5);
    cyc(4);
    chk(36'({port_line_o, port_line_oe_n_o, alu_port_in_o}), 36'h5A5);
    rchk(6'h2C, 32'h55);
    bus(1'b1, 6'h24, 32'h0);
    {ext_en, ext_val, seg_h_i, tick_long_i} <= {1'b1, 4'hA, 7'h55, 1'b1};
    cyc(6);
    chk(36'({port_line_oe_n_o, alu_port_in_o, wake_cnt[3:0]}), 36'hFA0);
    low_power_i <= 1'b1;
    ext_val <= 4'h9;
    cyc(6);
    low_power_i <= 1'b0;
    chk(36'(wake_cnt), 36'h1);
    rchk(6'h1C, 32'h94AA);
    alu_pick_bank_two_i <= 1'b1;
    @(posedge ref_clk_i);
    alu_pick_bank_two_i <= 1'b0;
    {alu_flag_set_i, alu_flag_idx_i} <= {1'b1, 4'h9};
    @(posedge ref_clk_i);
    alu_flag_set_i <= 1'b0;
    cyc(2);
    chk(36'(alu_flag_test_o), 36'h1);
    rchk(6'h20, 32'h200);
    rchk(6'h30, 32'h1);
    alu_pick_bank_one_i <= 1'b1;
    @(posedge ref_clk_i);
    alu_pick_bank_one_i <= 1'b0;
    cyc(2);
    chk(36'(alu_flag_test_o), 36'h0);
    for (int k = 0; k < 10; k++) begin
      @(posedge ref_clk_i);
      {alu_upd_i, alu_res_neg_i, alu_res_zero_i, alu_error_i, alu_adc_over_i, alu_adc_under_i} <= tbl[k][10:3];
      alu_jump_sel_i <= 2'(1 + k % 2);
      @(posedge ref_clk_i);
      alu_upd_i <= 3'h0;
      rchk(6'h28, 32'(tbl[k][2:0]));
      for (int j = 0; j < 3; j++) begin
        alu_jump_sel_i <= 2'(j);
        cyc(3);
        chk(36'(alu_jump_take_o), 36'(tbl[k][j]));
      end
    end
    bus(1'b0, 6'h3C, 32'h0);
    chk({rsp, rdat}, {2'h2, 32'hDEAD_BEEF});
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
